// file: common/anpr_pkg.sv
// Package for the auto-negotiation advertisement and partner ability registers.
// Assumes one clock domain and a plain register port with 16-bit data.
package anpr_pkg;

   // Register port widths.
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 16;

   // Register offsets; all three mode views of the advertisement share one address.
   localparam logic [15:0] ADV_OFFSET = 16'h2004;
   localparam logic [15:0] LP_OFFSET  = 16'h2005;

   // Low advertisement field and its reset value.
   localparam int unsigned ADV_LOW_W   = 5;
   localparam logic [4:0]  ADV_LOW_RST = 5'h00;

   // Fixed values of the SGMII views and the partner word reset value.
   localparam logic [6:0]  MEDIA_LOW_FIXED = 7'h01;
   localparam logic [15:0] SYS_ADV_VALUE   = 16'h0001;
   localparam logic [15:0] LP_RST          = 16'h0000;

   // Operating mode of the port, one-hot.
   typedef enum logic [2:0] {
      ANPR_MODE_FIBER = 3'h1,
      ANPR_MODE_MEDIA = 3'h2,
      ANPR_MODE_SYS   = 3'h4
   } anpr_mode_t;

   // One register port access.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } anpr_req_t;

   // Resolved state of the attached interface for the media view.
   typedef struct packed {
      logic       link;
      logic       duplex;
      logic [1:0] speed;
      logic       tx_pause;
      logic       rx_pause;
      logic       fiber;
   } anpr_media_t;

   // Events that let a pending advertisement take effect.
   typedef struct packed {
      logic sw_reset;
      logic an_restart;
      logic power_down;
   } anpr_ctl_t;

   // Received base page.
   typedef struct packed {
      logic              valid;
      logic [DATA_W-1:0] word;
   } anpr_page_t;

endpackage

// file: rtl/anpr_regs.sv
// Advertisement and link partner ability registers of one port.
// Assumes all inputs are synchronous to clk and base pages come one per pulse.
`timescale 1ns/1ps
module anpr_regs (
   // Clock and reset.
   input  wire logic                   clk,
   input  wire logic                   srst,
   // Register port.
   input  wire anpr_pkg::anpr_req_t    req,
   output logic [anpr_pkg::DATA_W-1:0] reg_rdata,
   // Port configuration and events.
   input  wire anpr_pkg::anpr_mode_t   mode,
   input  wire anpr_pkg::anpr_ctl_t    ctl,
   input  wire logic                   link_up,
   input  wire anpr_pkg::anpr_media_t  media,
   // Receive path.
   input  wire anpr_pkg::anpr_page_t   page,
   // Values used by the transmit path and link logic.
   output logic [anpr_pkg::ADV_LOW_W-1:0] adv_low_active,
   output logic [anpr_pkg::DATA_W-1:0]    partner_ability
);
   import anpr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State.

   // All flops of the block live in one struct.
   typedef struct packed {
      logic [ADV_LOW_W-1:0] adv_pending; // Value software wrote and reads back.
      logic [ADV_LOW_W-1:0] adv_active;  // Value in force on the link.
      logic [DATA_W-1:0]    lp;          // Captured partner ability.
      logic                 link_q;      // Link level one cycle ago.
      logic                 pd_q;        // Power-down level one cycle ago.
      logic [DATA_W-1:0]    rdata;       // Read data, valid the cycle after a read.
   } anpr_state_t;

   anpr_state_t st;      // Registered state.
   anpr_state_t next_st; // Next state.

   logic                 adv_hit;   // Access targets the advertisement.
   logic                 lp_hit;    // Access targets the partner word.
   logic                 adv_apply; // Pending advertisement takes effect.
   logic [DATA_W-1:0]    view;      // Advertisement view of the current mode.

   ////////////////////////////////////////////////////////////////////////////
   // Decode and event detection.

   // Address decode and the events that release the pending value.
   always_comb begin
      adv_hit   = (req.addr == ADV_OFFSET);
      lp_hit    = (req.addr == LP_OFFSET);
      // Power-down leaving and link loss are edges, so a level held for many
      // cycles applies the value only once.
      adv_apply = ctl.sw_reset | ctl.an_restart | (st.pd_q & ~ctl.power_down)
                | (st.link_q & ~link_up);
   end

   // Advertisement view by operating mode.
   always_comb begin
      case (mode)
         ANPR_MODE_FIBER: begin
            // Upper fields belong to other logic and read as zero here.
            view = {{(DATA_W-ADV_LOW_W){1'b0}}, st.adv_pending};
         end
         ANPR_MODE_MEDIA: begin
            view = {media.link,
                    2'b00,
                    media.duplex,
                    media.speed,
                    media.tx_pause,
                    media.rx_pause,
                    media.fiber,
                    MEDIA_LOW_FIXED};
         end
         ANPR_MODE_SYS: begin
            view = SYS_ADV_VALUE;
         end
         default: begin
            // An undefined mode code shows nothing rather than a stale view.
            view = '0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   // One process computes every next value.
   always_comb begin
      next_st        = st;
      next_st.link_q = link_up;
      next_st.pd_q   = ctl.power_down;

      // Software writes land only in the pending copy; the SGMII views are
      // read-only, so writes there are dropped.
      if (req.wr && adv_hit && (mode == ANPR_MODE_FIBER)) begin
         next_st.adv_pending = req.wdata[ADV_LOW_W-1:0];
      end
      // A software reset returns the field to its reset value.
      if (ctl.sw_reset) begin
         next_st.adv_pending = ADV_LOW_RST;
      end
      // On an apply event the newest pending value goes into force, so a
      // write in the same cycle as a restart, power-down exit or link loss is not lost.
      if (adv_apply) begin
         next_st.adv_active = next_st.adv_pending;
      end

      // Partner word: link loss or software reset wins over a page.
      if (!link_up || ctl.sw_reset) begin
         next_st.lp = LP_RST;
      end else if (page.valid) begin
         // Every bit maps one to one: next page, acknowledge, remote fault,
         // reserved, pause, half and full duplex, reserved low bits.
         next_st.lp = page.word;
      end

      // Read data for the cycle after the strobe; unmapped reads give zero.
      if (req.rd) begin
         if (adv_hit) begin
            next_st.rdata = view;
         end else if (lp_hit && (mode == ANPR_MODE_FIBER)) begin
            next_st.rdata = st.lp;
         end else begin
            next_st.rdata = '0;
         end
      end else begin
         next_st.rdata = '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   // Hardware reset clears everything to its documented value.
   // The reset branch assigns constants only, so the reset values cannot
   // depend on inputs that may still be settling while srst is high.
   // The edge detectors start low: a link that is already down, or a port
   // that is already powered down, does not count as an event after reset.
   // The trade-off is that a power-down exit in the very first cycle after
   // reset is not seen; firmware must not rely on that as an apply event.
   always_ff @(posedge clk) begin
      if (srst) begin
         st.adv_pending <= ADV_LOW_RST;
         st.adv_active  <= ADV_LOW_RST;
         st.lp          <= LP_RST;
         st.link_q      <= 1'b0;
         st.pd_q        <= 1'b0;
         st.rdata       <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs come straight from flops.
   // No logic sits between the state struct and the pins, so the transmit
   // path and the register port see glitch-free values with a full cycle of
   // timing slack.
   assign reg_rdata       = st.rdata;
   assign adv_low_active  = st.adv_active;
   assign partner_ability = st.lp;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // A read of the advertisement in a given mode.
   sequence s_adv_read(anpr_mode_t m);
      req.rd && adv_hit && (mode == m);
   endsequence

   // A clean write with no apply event in its own cycle.
   sequence s_quiet_write;
      req.wr && adv_hit && (mode == ANPR_MODE_FIBER) && !adv_apply;
   endsequence

   a_adv_held: assert property (s_quiet_write ##1 !adv_apply |=>
                  adv_low_active == $past(adv_low_active, 2))
      else $error("advertisement took effect without an apply event");

   a_adv_apply: assert property ((st.link_q && !link_up && !ctl.sw_reset) |=>
                  adv_low_active == st.adv_pending)
      else $error("link loss did not apply the pending advertisement");

   a_adv_swreset: assert property (ctl.sw_reset |=>
                  (st.adv_pending == ADV_LOW_RST) && (adv_low_active == ADV_LOW_RST))
      else $error("software reset did not clear the advertisement");

   a_fiber_readback: assert property (s_quiet_write ##1 s_adv_read(ANPR_MODE_FIBER)
                  |=> reg_rdata == {11'h000, $past(req.wdata[4:0], 2)})
      else $error("written advertisement did not read back");

   a_media_link: assert property (s_adv_read(ANPR_MODE_MEDIA) |=>
                  reg_rdata[15] == $past(media.link) && reg_rdata[14:13] == 2'b00)
      else $error("media view link bit wrong");

   a_media_duplex: assert property (s_adv_read(ANPR_MODE_MEDIA) |=>
                  reg_rdata[12] == $past(media.duplex))
      else $error("media view duplex bit wrong");

   a_media_speed: assert property (s_adv_read(ANPR_MODE_MEDIA) |=>
                  reg_rdata[11:10] == $past(media.speed))
      else $error("media view speed field wrong");

   a_media_pause: assert property (s_adv_read(ANPR_MODE_MEDIA) |=>
                  reg_rdata[9:8] == {$past(media.tx_pause), $past(media.rx_pause)})
      else $error("media view pause bits wrong");

   a_media_type: assert property (s_adv_read(ANPR_MODE_MEDIA) |=>
                  reg_rdata[7] == $past(media.fiber))
      else $error("media view media type wrong");

   a_media_fixed: assert property (s_adv_read(ANPR_MODE_MEDIA) |=>
                  reg_rdata[6:0] == 7'h01)
      else $error("media view low bits not fixed");

   a_sys_const: assert property (s_adv_read(ANPR_MODE_SYS) ##0 !req.wr |=>
                  reg_rdata == 16'h0001)
      else $error("system view not constant");

   a_lp_clear: assert property (!link_up |=> partner_ability == 16'h0000)
      else $error("partner word not cleared on link down");

   a_lp_load: assert property ((page.valid && link_up && !ctl.sw_reset) |=>
                  partner_ability == $past(page.word))
      else $error("partner word not loaded from page");

   a_lp_hold: assert property ((link_up && !page.valid && !ctl.sw_reset) |=>
                  $stable(partner_ability))
      else $error("partner word changed without a page");

   a_view_select: assert property (s_adv_read(ANPR_MODE_FIBER) |=>
                  reg_rdata[15:5] == 11'h000)
      else $error("fiber view shows foreign bits");

   ////////////////////////////////////////////////////////////////////////////
   // Further checks on the pending copy, the partner word and the read port.

   // A base page that the partner word accepts: link up and no software reset.
   sequence s_page_taken;
      page.valid && link_up && !ctl.sw_reset;
   endsequence

   // A cycle with no event that may release the pending advertisement.
   sequence s_no_apply;
      !adv_apply;
   endsequence

   // A read of the partner word address in the given mode.
   sequence s_lp_read(anpr_mode_t m);
      req.rd && lp_hit && (mode == m);
   endsequence

   // The value in force may only move on an apply event; this guards the
   // transmit path against a write leaking through early.
   a_active_stable: assert property (s_no_apply |=> $stable(adv_low_active))
      else $error("advertisement in force moved without an apply event");

   // A restart releases the pending value, including a write made in the
   // same cycle, since the apply copies the newest pending value.
   a_restart_apply: assert property ((ctl.an_restart && !ctl.sw_reset) |=>
                  adv_low_active == st.adv_pending)
      else $error("restart did not apply the pending advertisement");

   // Leaving power-down is an edge; the level alone must not apply anything,
   // which the stability check above covers for the held level.
   a_pd_exit: assert property ((st.pd_q && !ctl.power_down && !ctl.sw_reset) |=>
                  adv_low_active == st.adv_pending)
      else $error("power-down exit did not apply the pending advertisement");

   // The SGMII views are read-only; a write there must not reach the
   // pending copy, or a later mode change would show stale software data.
   a_sgmii_wr_drop: assert property ((req.wr && adv_hit && (mode != ANPR_MODE_FIBER)
                  && !ctl.sw_reset) |=> $stable(st.adv_pending))
      else $error("write in an SGMII view reached the pending advertisement");

   // The partner word is read-only; software cannot overwrite what the
   // partner sent.
   a_lp_wr_drop: assert property ((req.wr && lp_hit && link_up && !page.valid
                  && !ctl.sw_reset) |=> $stable(partner_ability))
      else $error("write changed the partner word");

   // In 1000BASE-X mode the partner address returns the captured word.
   // The word read is the one standing in the cycle of the strobe.
   a_lp_readback: assert property (s_lp_read(ANPR_MODE_FIBER) |=>
                  reg_rdata == $past(partner_ability))
      else $error("partner word read back wrong");

   // Outside 1000BASE-X mode the partner views belong to other logic, so
   // this block answers with zero rather than a misleading word.
   a_lp_hidden: assert property ((req.rd && lp_hit && (mode != ANPR_MODE_FIBER)) |=>
                  reg_rdata == 16'h0000)
      else $error("partner word visible outside fiber mode");

   // Reads of any other address return zero.
   // This keeps a mis-addressed poll from seeing a plausible value.
   a_unmapped: assert property ((req.rd && !adv_hit && !lp_hit) |=>
                  reg_rdata == 16'h0000)
      else $error("unmapped read returned data");

   // Read data stands for one cycle only and is zero otherwise.
   // A master that samples late therefore sees zero, not a stale word.
   a_rdata_idle: assert property (!req.rd |=> reg_rdata == 16'h0000)
      else $error("read data present without a read");

   // Software reset clears the partner word even while link stays up.
   // It wins over a page that arrives in the same cycle.
   a_lp_swreset: assert property (ctl.sw_reset |=> partner_ability == 16'h0000)
      else $error("software reset did not clear the partner word");

   // Next page ability of the partner comes from received bit 15.
   // The expansion logic reads this bit, so it must follow every page.
   a_lp_next_page: assert property (s_page_taken |=>
                  partner_ability[15] == $past(page.word[15]))
      else $error("partner next page bit wrong");

   // Acknowledge comes from received bit 14.
   // Link logic uses it to see that the partner heard our code word.
   a_lp_ack: assert property (s_page_taken |=>
                  partner_ability[14] == $past(page.word[14]))
      else $error("partner acknowledge bit wrong");

   // Remote fault is a two-bit code carried unchanged.
   // Bit order matters: a swap would turn offline into link failure.
   a_lp_fault: assert property (s_page_taken |=>
                  partner_ability[13:12] == $past(page.word[13:12]))
      else $error("partner remote fault field wrong");

   // Pause ability is a two-bit code carried unchanged.
   // Pause resolution downstream depends on both bits in their places.
   a_lp_pause: assert property (s_page_taken |=>
                  partner_ability[8:7] == $past(page.word[8:7]))
      else $error("partner pause field wrong");

   // Half duplex ability comes from received bit 6.
   // Duplex resolution downstream reads it directly.
   a_lp_half: assert property (s_page_taken |=>
                  partner_ability[6] == $past(page.word[6]))
      else $error("partner half duplex bit wrong");

   // Full duplex ability comes from received bit 5.
   // Duplex resolution downstream reads it directly.
   a_lp_full: assert property (s_page_taken |=>
                  partner_ability[5] == $past(page.word[5]))
      else $error("partner full duplex bit wrong");

   // Reserved bits are captured as received, not forced to zero, so that a
   // partner breaking the rules stays visible to software.
   a_lp_reserved: assert property (s_page_taken |=>
                  {partner_ability[11:9], partner_ability[4:0]}
                  == {$past(page.word[11:9]), $past(page.word[4:0])})
      else $error("partner reserved bits not captured");

endmodule

// file: sim/anpr_lp_model.sv
// Remote link partner model that sends base pages into the receive path.
// Assumes the bench asks for one page per send pulse, in step with clk.
`timescale 1ns/1ps
module anpr_lp_model (
   // Clock and reset.
   input  wire logic                 clk,
   input  wire logic                 srst,
   // Page request from the bench.
   input  wire logic                 send,
   input  wire logic                 bad,
   input  wire logic [15:0]          word,
   // Received page towards the block.
   output anpr_pkg::anpr_page_t      page
);
   import anpr_pkg::*;
   // One page per send; between pages the word inverts so stale data never looks valid.
   always_ff @(posedge clk) begin
      if (srst) begin
         page <= '{valid: 1'b0, word: 16'h0000};
      end else if (send) begin
         page.valid <= 1'b1;
         // A compliant partner sends zero in the low reserved bits.
         page.word  <= bad ? word : {word[15:5], 5'h00};
      end else begin
         page.valid <= 1'b0;
         page.word  <= ~page.word;
      end
   end
endmodule

// file: sim/tb.sv
// Self-checking bench for the advertisement and partner ability registers.
// Assumes a 200 MHz clock and the partner model on the receive path.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb;
   import anpr_pkg::*;
   logic clk = 1'b0, srst = 1'b1, link_up = 1'b0, send = 1'b0, bad = 1'b0;
   logic [15:0] word = 16'h0000, d;
   logic [4:0] w, prev;
   anpr_req_t req = '0;
   anpr_mode_t mode = ANPR_MODE_FIBER;
   anpr_ctl_t ctl = '0;
   anpr_media_t media = '0;
   anpr_page_t page;
   logic [15:0] rdata, pa;
   logic [4:0] act;
   int n_mismatch = 0, check_count = 0;
   always #2.5 clk = ~clk;
   anpr_lp_model anpr_lp_model_i (.clk(clk), .srst(srst), .send(send), .bad(bad),
      .word(word), .page(page));
   anpr_regs anpr_regs_i (.clk(clk), .srst(srst), .req(req), .reg_rdata(rdata),
      .mode(mode), .ctl(ctl), .link_up(link_up), .media(media), .page(page),
      .adv_low_active(act), .partner_ability(pa));
   ////////////////////////////////////////////////////////////////////////////
   // Register port: one-cycle strobes, read data sampled in the cycle after.
   task automatic wr(input logic [15:0] a, input logic [15:0] v);
      @(posedge clk);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] v);
      @(posedge clk);
      req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 v = rdata;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Each write must wait for its apply event; software reset clears instead.
   task automatic t_apply;
      prev = 5'h00;
      for (int i = 0; i < 4; i++) begin
         w = 5'h11 + 5'(i);
         if (i == 1) ctl.power_down <= 1'b1;
         wr(ADV_OFFSET, {11'h7FF, w});
         rd(ADV_OFFSET, d);
         `CHK("adv_pending", {11'h000, w}, d)
         `CHK("adv_held", prev, act)
         @(posedge clk);
         case (i)
            0: ctl.an_restart <= 1'b1;
            1: ctl.power_down <= 1'b0;
            2: link_up <= 1'b0;
            default: ctl.sw_reset <= 1'b1;
         endcase
         @(posedge clk);
         ctl <= '0;
         link_up <= 1'b1;
         prev = (i == 3) ? 5'h00 : w;
         #1 `CHK("adv_active", prev, act)
      end
      $display("test apply done");
   endtask
   // Media view follows the attached interface for every speed code.
   task automatic t_media;
      anpr_media_t m;
      logic [15:0] e;
      mode <= ANPR_MODE_MEDIA;
      for (int s = 0; s < 8; s++) begin
         m = '{link: s[0], duplex: s[1], speed: 2'(s >> 1), tx_pause: s[2],
               rx_pause: ~s[0], fiber: s[1] ^ s[2]};
         e = {m.link, 2'b00, m.duplex, m.speed, m.tx_pause, m.rx_pause, m.fiber, 7'h01};
         media <= m;
         rd(ADV_OFFSET, d);
         `CHK("adv_media", e, d)
      end
      $display("test media done");
   endtask
   // System view is constant and refuses writes; fiber pending stays intact.
   task automatic t_system;
      mode <= ANPR_MODE_SYS;
      wr(ADV_OFFSET, 16'h1234);
      rd(ADV_OFFSET, d);
      `CHK("adv_system", SYS_ADV_VALUE, d)
      mode <= ANPR_MODE_FIBER;
      rd(ADV_OFFSET, d);
      `CHK("adv_fiber_kept", {11'h000, prev}, d)
      rd(16'h0000, d);
      `CHK("unmapped", 16'h0000, d)
      $display("test system done");
   endtask
   // Pages load every field; link loss clears the word.
   task automatic t_partner;
      for (int k = 0; k < 5; k++) begin
         bad <= (k == 4);
         word <= (k == 4) ? 16'h0E1F : {k[0], k[1], 2'(k), 3'b000, 2'(k), k[0], ~k[0], 5'h00};
         @(posedge clk);
         send <= 1'b1;
         @(posedge clk);
         send <= 1'b0;
         @(posedge clk);
         #1 `CHK("lp_word", word, pa)
         rd(LP_OFFSET, d);
         `CHK("lp_read", word, d)
      end
      link_up <= 1'b0;
      @(posedge clk);
      #1 `CHK("lp_cleared", LP_RST, pa)
      $display("test partner done");
   endtask
   // Values right after hardware reset.
   task automatic t_reset;
      rd(ADV_OFFSET, d);
      `CHK("adv_reset", 16'h0000, d)
      `CHK("lp_reset", LP_RST, pa)
      $display("test reset done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // A hang counts as a mismatch and ends in the same report.
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      give_verdict();
   end
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      link_up <= 1'b1;
      t_reset();
      t_apply();
      t_media();
      t_system();
      t_partner();
      give_verdict();
   end
endmodule
